// File: fifo_rt_pkg.sv
// Constants and types for the retransmit-from-anchor FIFO read side.
// Assumes one clock for bus, write port and read port.
`default_nettype none
package fifo_rt_pkg;
  localparam int DATA_W = 40;
  localparam int ADDR_W = 14;
  localparam int DEPTH  = 16384;
  localparam int PTR_W  = 15;
  localparam int GAP_BITS = 1280;
  localparam logic [PTR_W-1:0] FULL_COUNT = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] STEP_SDR = 15'h0001;
  localparam logic [PTR_W-1:0] STEP_DDR = 15'h0002;
  localparam logic [1:0] WIDTH_40 = 2'h0;
  localparam logic [1:0] WIDTH_20 = 2'h1;
  localparam logic [1:0] WIDTH_10 = 2'h2;
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ANCHOR_OFFSET = 8'h08;
  localparam logic [7:0] COUNT_OFFSET  = 8'h0C;
  localparam int CTRL_FALL_THROUGH_MODE_BIT  = 0;
  localparam int CTRL_DDR_BIT   = 1;
  localparam int CTRL_WIDTH_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Bit order matches the control register layout
  typedef struct packed {
    logic [1:0] width;
    logic       ddr;
    logic       fall_through_mode;
  } cfg_type;

  typedef struct packed {
    logic gap_ok;
    logic setup;
    logic anchor_set;
  } status_type;

  typedef struct packed {
    logic [DATA_W-1:0] fall;
    logic [DATA_W-1:0] rise;
  } pair_type;

  typedef enum {RD_NORMAL, RD_SETUP, RD_LOAD} rd_state_type;

  function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] w);
    case (w)
      WIDTH_20: width_mask = 40'h00000FFFFF;
      WIDTH_10: width_mask = 40'h00000003FF;
      default:  width_mask = 40'hFFFFFFFFFF;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] gap_words(input logic [1:0] w);
    case (w)
      WIDTH_20: gap_words = PTR_W'(GAP_BITS / 20);
      WIDTH_10: gap_words = PTR_W'(GAP_BITS / 10);
      default:  gap_words = PTR_W'(GAP_BITS / 40);
    endcase
  endfunction
endpackage
`default_nettype wire

// File: fifo_mem.sv
// Storage array: one write port, reads of a word and its pair partner.
// Assumes addresses are in range; reads are combinational.
`timescale 1ns/1ns
`default_nettype none
module fifo_mem (
  input  wire logic                            hclk,
  input  wire logic                            wr_en,
  input  wire logic [fifo_rt_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [fifo_rt_pkg::DATA_W-1:0]  wr_data,
  input  wire logic [fifo_rt_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [fifo_rt_pkg::DATA_W-1:0]  rd_rise,
  output logic      [fifo_rt_pkg::DATA_W-1:0]  rd_fall
);
  import fifo_rt_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] rd_addr_odd;

  assign rd_addr_odd = rd_addr + ADDR_W'(1);
  assign rd_rise = mem[rd_addr];
  assign rd_fall = mem[rd_addr_odd];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// File: fifo_rt_regs.sv
// AHB-Lite slave holding mode control and showing read-side state.
// Assumes single word transfers; always ready, always OKAY.
`timescale 1ns/1ns
`default_nettype none
module fifo_rt_regs (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire fifo_rt_pkg::status_type       status,
  input  wire logic [fifo_rt_pkg::PTR_W-1:0] anchor_ptr,
  input  wire logic [fifo_rt_pkg::PTR_W-1:0] fill_count,
  output fifo_rt_pkg::cfg_type               cfg
);
  import fifo_rt_pkg::*;

  logic        take;
  logic [31:0] rd_word;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  cfg_type     cfg_reg;
  logic [31:0] hrdata_reg;

  // Only word transfers are decoded; others leave the registers alone
  assign take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  assign rd_word = (haddr[7:0] == CTRL_OFFSET)   ? 32'(cfg_reg) :
                   (haddr[7:0] == STATUS_OFFSET) ? 32'(status) :
                   (haddr[7:0] == ANCHOR_OFFSET) ? 32'(anchor_ptr) :
                   (haddr[7:0] == COUNT_OFFSET)  ? 32'(fill_count) :
                   32'h00000000;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign cfg = cfg_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= cfg_type'(CTRL_RESET);
    end else if (wr_pend_reg && wr_addr_reg == CTRL_OFFSET) begin
      cfg_reg <= cfg_type'(hwdata[3:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata_reg <= rd_word;
    end
  end
endmodule
`default_nettype wire

// File: fifo_retransmit_from_mark.sv
// Read side of a FIFO with retransmit from an anchored output word.
// Assumes pins synchronous to hclk; mode set over AHB-Lite.
// How it works
// - Anchor may be set again and again; newest setting replaces old.
// - In DDR the anchor covers the rise/fall pair of one cycle.
// - Retransmit works in standard and fall-through timing.
// - Standard: anchor entry needs mark high and empty flag high.
// - Fall-through: anchor entry needs mark high, output-ready low.
// - Anchor is the output register word, pair-aligned in DDR, rise first.
// - Anchor mode lasts until an edge sees mark low.
// - With anchor set, retransmit request low starts setup.
// - Standard: empty flag low during setup, then reads from anchor.
// - Fall-through: output-ready high during setup, reads blocked.
// - Fall-through: anchor word loads next edge regardless of enable.
// - Fall-through: later words advance only with read enable low.
// - Writes continue, except one landing on the anchor.
// - Write pointer never passes the anchor while it is set.
// - Input width 40, 20 or 10 bits picks the used data bits.
// - Standard: empty flag returns high one edge after setup starts.
// - Fall-through: output-ready returns low one edge after setup starts.
// - Fall-through timing only in single data rate.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fifo_retransmit_from_mark (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire logic                           write_enable_n,
  input  wire logic [fifo_rt_pkg::DATA_W-1:0] write_data_in,
  output logic                                full_flag_n,
  input  wire logic                           read_enable_n,
  input  wire logic                           mark_request,
  input  wire logic                           retransmit_request_n,
  output fifo_rt_pkg::pair_type               read_data_out,
  output logic                                empty_flag_n,
  output logic                                output_ready_n
);
  import fifo_rt_pkg::*;

  cfg_type           cfg;
  status_type        status;
  rd_state_type      state_reg;
  rd_state_type      state_next;
  logic [PTR_W-1:0]  wptr_reg;
  logic [PTR_W-1:0]  rptr_reg;
  logic [PTR_W-1:0]  rptr_next;
  logic [PTR_W-1:0]  anchor_ptr_reg;
  logic [PTR_W-1:0]  out_ptr_reg;
  logic [PTR_W-1:0]  out_ptr_aligned;
  logic              anchor_set_reg;
  logic              out_valid_reg;
  pair_type          out_pair_reg;
  logic [PTR_W-1:0]  count;
  logic [PTR_W-1:0]  step;
  logic [DATA_W-1:0] mem_rise;
  logic [DATA_W-1:0] mem_fall;
  logic [DATA_W-1:0] wr_data;
  logic              fall_through_mode_eff;
  logic              idle;
  logic              avail;
  logic              full;
  logic              anchor_block;
  logic              wr_go;
  logic              rt_go;
  logic              std_rd;
  logic              ft_load;
  logic              load;
  logic              drain;
  logic              mark_ok;
  logic              enter;

  // Compare storage units; in DDR a unit is an even/odd pair
  function automatic logic same_unit(input logic [PTR_W-1:0] a,
                                     input logic [PTR_W-1:0] b,
                                     input logic             ddr);
    same_unit = ddr ? (a[ADDR_W-1:1] == b[ADDR_W-1:1])
                    : (a[ADDR_W-1:0] == b[ADDR_W-1:0]);
  endfunction

  fifo_rt_regs u_regs (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .status     (status),
    .anchor_ptr (anchor_ptr_reg),
    .fill_count (count),
    .cfg        (cfg)
  );

  fifo_mem u_mem (
    .hclk    (hclk),
    .wr_en   (wr_go),
    .wr_addr (wptr_reg[ADDR_W-1:0]),
    .wr_data (wr_data),
    .rd_addr (rptr_reg[ADDR_W-1:0]),
    .rd_rise (mem_rise),
    .rd_fall (mem_fall)
  );

  assign fall_through_mode_eff = cfg.fall_through_mode & ~cfg.ddr;
  assign step = cfg.ddr ? STEP_DDR : STEP_SDR;
  assign count = wptr_reg - rptr_reg;
  assign avail = count >= step;
  assign full = count == FULL_COUNT;
  assign idle = state_reg == RD_NORMAL;
  assign wr_data = write_data_in & width_mask(cfg.width);

  // Write side keeps running; only the anchored unit is guarded
  assign anchor_block = anchor_set_reg &
                        same_unit(wptr_reg, anchor_ptr_reg, cfg.ddr);
  assign wr_go = ~write_enable_n & ~full & ~anchor_block;
  assign full_flag_n = ~(full | anchor_block);

  assign rt_go = anchor_set_reg & ~retransmit_request_n;
  assign std_rd = ~fall_through_mode_eff & idle & ~read_enable_n & avail;
  assign ft_load = fall_through_mode_eff & ((state_reg == RD_LOAD) |
                   (idle & avail & (~out_valid_reg | ~read_enable_n)));
  assign load = (std_rd | ft_load) & ~rt_go;
  assign drain = fall_through_mode_eff & idle & out_valid_reg & ~read_enable_n &
                 ~avail & ~rt_go;

  // Inactive flag of the other timing mode is parked high
  assign empty_flag_n = fall_through_mode_eff | (idle & avail);
  assign output_ready_n = ~fall_through_mode_eff |
                          ~((state_reg == RD_LOAD) |
                            (idle & out_valid_reg));
  assign mark_ok = fall_through_mode_eff ? ~output_ready_n : empty_flag_n;
  assign enter = mark_request & ~anchor_set_reg & mark_ok;
  assign out_ptr_aligned = cfg.ddr ? {out_ptr_reg[PTR_W-1:1], 1'b0}
                                   : out_ptr_reg;

  assign rptr_next = rt_go ? anchor_ptr_reg :
                     load  ? rptr_reg + step : rptr_reg;

  always_comb begin
    state_next = RD_NORMAL;
    case (state_reg)
      RD_NORMAL: state_next = RD_NORMAL;
      RD_SETUP:  state_next = fall_through_mode_eff ? RD_LOAD : RD_NORMAL;
      RD_LOAD:   state_next = RD_NORMAL;
      default:   state_next = RD_NORMAL;
    endcase
    if (rt_go) begin
      state_next = RD_SETUP;
    end
  end

  assign status.anchor_set = anchor_set_reg;
  assign status.setup = ~idle;
  assign status.gap_ok = anchor_set_reg &
    ((wptr_reg - anchor_ptr_reg) >= gap_words(cfg.width));
  assign read_data_out = out_pair_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RD_NORMAL;
      rptr_reg  <= '0;
      wptr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      rptr_reg  <= rptr_next;
      wptr_reg  <= wr_go ? wptr_reg + STEP_SDR : wptr_reg;
    end
  end

  // Entry only from outside anchor mode, so one setting per mark pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      anchor_set_reg <= 1'b0;
      anchor_ptr_reg <= '0;
    end else begin
      anchor_set_reg <= mark_request & (anchor_set_reg | enter);
      if (enter) begin
        anchor_ptr_reg <= out_ptr_aligned;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_pair_reg  <= '0;
      out_ptr_reg   <= '0;
      out_valid_reg <= 1'b0;
    end else if (load) begin
      out_pair_reg.rise <= mem_rise;
      out_pair_reg.fall <= cfg.ddr ? mem_fall : '0;
      out_ptr_reg       <= rptr_reg;
      out_valid_reg     <= 1'b1;
    end else if (drain) begin
      out_valid_reg <= 1'b0;
    end
  end

  property p_std_setup_low;
    @(posedge hclk) disable iff (!hresetn)
    rt_go && !fall_through_mode_eff |=> !empty_flag_n;
  endproperty
  a_std_setup_low: assert property (p_std_setup_low)
    else $error("empty flag not low after retransmit");

  property p_std_setup_done;
    @(posedge hclk) disable iff (!hresetn)
    (rt_go && !fall_through_mode_eff) ##1 (!rt_go && !fall_through_mode_eff) |=> idle;
  endproperty
  a_std_setup_done: assert property (p_std_setup_done)
    else $error("standard setup not done in one cycle");

  property p_ft_setup_high;
    @(posedge hclk) disable iff (!hresetn)
    rt_go && fall_through_mode_eff |=> output_ready_n;
  endproperty
  a_ft_setup_high: assert property (p_ft_setup_high)
    else $error("output ready not high after retransmit");

  property p_ft_setup_done;
    @(posedge hclk) disable iff (!hresetn)
    (rt_go && fall_through_mode_eff) ##1 (!rt_go && fall_through_mode_eff) |=> !output_ready_n;
  endproperty
  a_ft_setup_done: assert property (p_ft_setup_done)
    else $error("output ready not low one cycle after setup");

  property p_ft_first_word;
    @(posedge hclk) disable iff (!hresetn)
    (rt_go && fall_through_mode_eff) ##1 (!rt_go && fall_through_mode_eff) ##1
    (!rt_go && fall_through_mode_eff && anchor_set_reg)
    |=> out_ptr_reg == $past(anchor_ptr_reg);
  endproperty
  a_ft_first_word: assert property (p_ft_first_word)
    else $error("anchor word not loaded after setup");

  property p_rewind;
    @(posedge hclk) disable iff (!hresetn)
    rt_go |=> rptr_reg == $past(anchor_ptr_reg);
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("read pointer not returned to anchor");

  property p_anchor_capture;
    @(posedge hclk) disable iff (!hresetn)
    enter |=> anchor_set_reg && anchor_ptr_reg == $past(out_ptr_aligned);
  endproperty
  a_anchor_capture: assert property (p_anchor_capture)
    else $error("anchor not taken from output word");

  property p_anchor_exit;
    @(posedge hclk) disable iff (!hresetn)
    !mark_request |=> !anchor_set_reg;
  endproperty
  a_anchor_exit: assert property (p_anchor_exit)
    else $error("anchor mode kept with mark low");

  property p_std_no_entry;
    @(posedge hclk) disable iff (!hresetn)
    mark_request && !anchor_set_reg && !fall_through_mode_eff && !empty_flag_n
    |=> !anchor_set_reg;
  endproperty
  a_std_no_entry: assert property (p_std_no_entry)
    else $error("anchor entered while empty");

  property p_guard_write;
    @(posedge hclk) disable iff (!hresetn)
    anchor_block |=> wptr_reg == $past(wptr_reg);
  endproperty
  a_guard_write: assert property (p_guard_write)
    else $error("write pointer moved onto anchor");

  property p_ddr_pair;
    @(posedge hclk) disable iff (!hresetn)
    enter && cfg.ddr |=> anchor_ptr_reg[0] == 1'b0;
  endproperty
  a_ddr_pair: assert property (p_ddr_pair)
    else $error("DDR anchor not pair aligned");
endmodule
`default_nettype wire

// File: fifo_host_model.sv
// Host model: write side of the FIFO, sends a counting word stream.
// Assumes a word is taken at each edge with enable low and room left.
`timescale 1ns/1ns
`default_nettype none
module fifo_host_model (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      wr_on,
  input  wire logic                      stall,
  input  wire logic                      full_flag_n,
  output logic                           write_enable_n,
  output logic [fifo_rt_pkg::DATA_W-1:0] write_data_in,
  output logic [31:0]                    sent
);
  import fifo_rt_pkg::*;
  logic        taken;
  logic        hold;
  logic        go;
  logic [31:0] sent_next;
  assign taken = !write_enable_n && full_flag_n;
  assign sent_next = taken ? sent + 32'h1 : sent;
  // A refused word is offered again while writes are wanted
  assign hold = !write_enable_n && !full_flag_n && wr_on;
  assign go = wr_on && !stall;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent <= 32'h0;
      write_enable_n <= 1'b1;
      write_data_in <= 40'h0;
    end else begin
      sent <= sent_next;
      if (!hold) begin
        write_enable_n <= !go;
        // Idle data inverted so a stale word never looks fresh
        write_data_in <= go ? {8'h5A, sent_next} : ~{8'h5A, sent_next};
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the retransmit-from-anchor FIFO read side.
// Assumes the host model supplies a counting write stream.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fifo_rt_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        write_enable_n;
  logic [39:0] write_data_in;
  logic        full_flag_n;
  logic        read_enable_n;
  logic        mark_request;
  logic        retransmit_request_n;
  pair_type    read_data_out;
  logic        empty_flag_n;
  logic        output_ready_n;
  logic        wr_on;
  logic        stall;
  logic [31:0] sent;
  logic [31:0] tgt;
  logic [31:0] rdat;
  logic [1:0]  wsel;
  logic        ddr_on;
  logic        fall_on;
  int          miscompares;
  int          check_count;
  int          k;

  always #10 hclk = ~hclk;
  always @(posedge hclk) stall <= ($urandom_range(3) == 0);

  fifo_retransmit_from_mark i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .write_enable_n(write_enable_n),
    .write_data_in(write_data_in), .full_flag_n(full_flag_n),
    .read_enable_n(read_enable_n), .mark_request(mark_request),
    .retransmit_request_n(retransmit_request_n),
    .read_data_out(read_data_out), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n));
  fifo_host_model i_host (.hclk(hclk), .hresetn(hresetn), .wr_on(wr_on),
    .stall(stall), .full_flag_n(full_flag_n),
    .write_enable_n(write_enable_n), .write_data_in(write_data_in),
    .sent(sent));

  function automatic logic [39:0] pat(int n);
    logic [39:0] m;
    m = (wsel == WIDTH_20) ? 40'h00000FFFFF :
        (wsel == WIDTH_10) ? 40'h00000003FF : 40'hFFFFFFFFFF;
    return {8'h5A, 32'(n)} & m;
  endfunction
  function automatic logic [79:0] expw(int n);
    return ddr_on ? {pat(n + 1), pat(n)} : {40'h0, pat(n)};
  endfunction

  task automatic conclude();
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [79:0] seen, logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fail_wait();
    miscompares++;
    $display("mismatch wait expected done seen timeout");
    conclude();
  endtask
  task automatic await(int sel, logic v, int lim);
    int n;
    logic s;
    n = 0;
    do begin
      @(negedge hclk);
      s = (sel == 0) ? empty_flag_n : (sel == 1) ? output_ready_n :
          (sel == 2) ? full_flag_n : (sent >= tgt);
      n++;
    end while (s !== v && n < lim);
    if (s !== v)
      fail_wait();
  endtask
  task automatic hwait();
    int n;
    logic r;
    n = 0;
    do begin
      // Taken at the edge itself: flops have not yet moved
      @(posedge hclk);
      r = hreadyout;
      rdat = hrdata;
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1)
      fail_wait();
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hwait();
    check("hresp", hresp, HRESP_OKAY);
  endtask
  task automatic rst(logic [3:0] c);
    @(posedge hclk);
    hresetn <= 1'b0;
    wr_on <= 1'b0;
    mark_request <= 1'b0;
    retransmit_request_n <= 1'b1;
    read_enable_n <= 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    if (c != 4'h0)
      ahb(1'b1, CTRL_OFFSET, {28'h0, c});
    wsel = c[3:2];
    ddr_on = c[1];
    fall_on = c[0] & ~c[1];
  endtask
  task automatic wr_upto(int n);
    tgt = n;
    @(posedge hclk);
    wr_on <= 1'b1;
    await(3, 1'b1, 400);
    @(posedge hclk);
    wr_on <= 1'b0;
  endtask
  task automatic rdc(int n);
    await(fall_on ? 1 : 0, !fall_on, 300);
    @(posedge hclk);
    read_enable_n <= 1'b0;
    @(posedge hclk);
    read_enable_n <= 1'b1;
    @(negedge hclk);
    check("read_data_out", read_data_out, expw(n));
  endtask
  task automatic retx();
    @(posedge hclk);
    retransmit_request_n <= 1'b0;
    @(posedge hclk);
    retransmit_request_n <= 1'b1;
    @(negedge hclk);
    check("setup", fall_on ? output_ready_n : empty_flag_n, fall_on);
    @(negedge hclk);
    check("ready", fall_on ? output_ready_n : empty_flag_n, !fall_on);
  endtask
  task automatic mark();
    @(posedge hclk);
    mark_request <= 1'b0;
    @(posedge hclk);
    mark_request <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic anchor_chk(int n);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check("status", rdat[2:0], 3'h5);
    ahb(1'b0, ANCHOR_OFFSET, 32'h0);
    check("anchor", rdat, n);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    wr_on = 1'b0;
    read_enable_n = 1'b1;
    mark_request = 1'b0;
    retransmit_request_n = 1'b1;
    tgt = 32'h0;
    miscompares = 0;
    check_count = 0;
    void'($urandom(55));
    rst(4'h0);
    @(negedge hclk);
    check("rst_flags", {empty_flag_n, output_ready_n, full_flag_n}, 3'h3);
    check("rst_out", read_data_out, 80'h0);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl", rdat, 32'h0);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    check("unmapped", rdat, 32'h0);
    mark();
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check("no_anchor", rdat[0], 1'b0);
    for (int w = 2; w >= 0; w--) begin
      rst({w[1:0], 2'h0});
      wr_upto(8);
      for (int i = 0; i < 3; i++)
        rdc(i);
      ahb(1'b0, COUNT_OFFSET, 32'h0);
      check("count", rdat, sent - 32'h3);
    end
    wr_upto(40);
    k = 2 + $urandom_range(2);
    for (int i = 3; i <= k; i++)
      rdc(i);
    mark();
    anchor_chk(k);
    rdc(k + 1);
    rdc(k + 2);
    retx();
    rdc(k);
    rdc(k + 1);
    retx();
    rdc(k);
    rdc(k + 1);
    @(posedge hclk);
    mark_request <= 1'b0;
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check("anchor_off", rdat[0], 1'b0);
    mark();
    anchor_chk(k + 1);
    @(posedge hclk);
    wr_on <= 1'b1;
    await(2, 1'b0, 40000);
    repeat (8) @(posedge hclk);
    wr_on <= 1'b0;
    check("sent", sent, 16384 + k + 1);
    retx();
    rdc(k + 1);
    rdc(k + 2);
    rst(4'h1);
    wr_upto(40);
    await(1, 1'b0, 300);
    check("first", read_data_out, expw(0));
    k = 1 + $urandom_range(2);
    for (int i = 1; i <= k; i++)
      rdc(i);
    mark();
    anchor_chk(k);
    rdc(k + 1);
    retx();
    check("old_word", read_data_out, expw(k + 1));
    @(negedge hclk);
    check("reload", read_data_out, expw(k));
    repeat (3) @(negedge hclk);
    check("stay", read_data_out, expw(k));
    rdc(k + 1);
    rst(4'h3);
    wr_upto(40);
    @(negedge hclk);
    check("no_fall", output_ready_n, 1'b1);
    rdc(0);
    rdc(2);
    mark();
    anchor_chk(2);
    rdc(4);
    retx();
    rdc(2);
    conclude();
  end
endmodule
`default_nettype wire
